// file: logic/sbfp_pkg.sv
// sbfp_pkg: constants for the serial boot flash port
// assumes a word-addressed slave port and one 125 MHz clock
`default_nettype none
package sbfp_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int ROM_WORDS = 256;
    localparam int ROM_BYTES = 1024;
    localparam int ROM_AW = 8;
    // register word offsets
    localparam logic [8:0] OFS_ROM_BASE = 9'h000;
    localparam logic [8:0] OFS_ROM_LAST = 9'h0FF;
    localparam logic [8:0] OFS_RECEIVE_WORD = 9'h100;
    localparam logic [8:0] OFS_TRANSMIT_WORD = 9'h101;
    localparam logic [8:0] OFS_LINK_STATUS = 9'h102;
    localparam logic [8:0] OFS_LINK_CONTROL = 9'h103;
    localparam logic [8:0] OFS_RESERVED_WORD = 9'h104;
    localparam logic [8:0] OFS_TARGET_SELECT = 9'h105;
    localparam logic [8:0] OFS_LAST_WORD_MARKER = 9'h106;
    // field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RXRDY_BIT = 1;
    localparam int STAT_OVERRUN_BIT = 2;
    localparam int CTRL_FORCE_SEL_BIT = 0;
    localparam int SEL_TARGET0_BIT = 0;
    // reset values
    localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RST_TARGET_SELECT = 32'h0000_0001;
    localparam logic [31:0] RST_MARKER = 32'h0000_0000;
    // serial timing: system clocks per serial clock half period
    localparam int CLK_MHZ = 125;
    localparam int SCLK_HALF_NS = 32;
    localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
    localparam int SHIFT_BITS = 8;
    localparam int READ_LATENCY = 2;

    typedef enum logic [0:0]
    {
        SHIFT_IDLE = 1'b0,
        SHIFT_RUN = 1'b1
    } sbfp_shift_e;
endpackage : sbfp_pkg
`default_nettype wire

// file: logic/sbfp_boot_rom.sv
// sbfp_boot_rom: 256-word read-only boot-loader store, registered read
// assumes the image arrives as a parameter; no write path exists
`timescale 1ns/1ps
`default_nettype none
module sbfp_boot_rom
    import sbfp_pkg::*;
#(
    parameter logic [31:0] ROM_IMAGE [ROM_WORDS] = '{default: 32'h0000_0000}
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // read port
    input wire logic rdEn,
    input wire logic [ROM_AW-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] rdData_ff;
    logic [DATA_W-1:0] nxt_rdData;

    always_comb
    begin
        nxt_rdData = rdData_ff;
        if (rdEn)
        begin
            nxt_rdData = ROM_IMAGE[rdAddr];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdData_ff <= 32'h0000_0000;
        end
        else
        begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign rdData = rdData_ff;
endmodule : sbfp_boot_rom
`default_nettype wire

// file: logic/sbfp_top.sv
// sbfp_top: boot ROM plus serial flash register window on one slave port
// assumes the flash pins are wired to dedicated configuration pins
`timescale 1ns/1ps
`default_nettype none
module sbfp_top
    import sbfp_pkg::*;
#(
    parameter logic [31:0] ROM_IMAGE [ROM_WORDS] = '{default: 32'h0000_0000}
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // slave port
    input wire logic chipSelect,
    input wire logic [ADDR_W-1:0] address,
    input wire logic readEn,
    input wire logic writeEn,
    input wire logic [DATA_W-1:0] writeData,
    output logic [DATA_W-1:0] readData,
    output logic readValid,
    // dedicated flash pins
    output logic flashClk,
    output logic flashSelectN,
    output logic flashDataOut,
    input wire logic flashDataIn
);
    // input synchroniser for the flash data pin
    logic dinS1_ff, dinS2_ff, dinS3_ff, dinVal_ff;
    logic nxt_dinVal;

    always_comb
    begin
        nxt_dinVal = dinVal_ff;
        if (dinS2_ff == dinS3_ff)
        begin
            nxt_dinVal = dinS3_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dinS1_ff <= 1'b0;
            dinS2_ff <= 1'b0;
            dinS3_ff <= 1'b0;
            dinVal_ff <= 1'b0;
        end
        else
        begin
            dinS1_ff <= flashDataIn;
            dinS2_ff <= dinS1_ff;
            dinS3_ff <= dinS2_ff;
            dinVal_ff <= nxt_dinVal;
        end
    end

    // boot code store
    logic romRd;
    logic [DATA_W-1:0] romData;

    assign romRd = chipSelect && readEn && (address <= OFS_ROM_LAST);

    sbfp_boot_rom #(.ROM_IMAGE(ROM_IMAGE)) u_rom
    (
        .clk(clk),
        .resetn(resetn),
        .rdEn(romRd),
        .rdAddr(address[ROM_AW-1:0]),
        .rdData(romData)
    );

    // main state: bus slave, registers, shifter
    sbfp_shift_e state_ff, nxt_state;
    logic [DATA_W-1:0] readData_ff, nxt_readData;
    logic readValid_ff, nxt_readValid;
    logic rdPend_ff, nxt_rdPend;
    logic rdRom_ff, nxt_rdRom;
    logic [DATA_W-1:0] rdWord_ff, nxt_rdWord;
    logic [DATA_W-1:0] control_ff, nxt_control;
    logic [DATA_W-1:0] targetSel_ff, nxt_targetSel;
    logic [DATA_W-1:0] marker_ff, nxt_marker;
    logic [7:0] rxWord_ff, nxt_rxWord;
    logic [7:0] txShift_ff, nxt_txShift;
    logic [2:0] bitCnt_ff, nxt_bitCnt;
    logic [7:0] divCnt_ff, nxt_divCnt;
    logic rxReady_ff, nxt_rxReady;
    logic overrun_ff, nxt_overrun;
    logic sclk_ff, nxt_sclk;
    logic selN_ff, nxt_selN;
    logic dout_ff, nxt_dout;
    logic tick, wrAcc, rdAcc, done;
    logic [DATA_W-1:0] statusWord;

    assign wrAcc = chipSelect && writeEn;
    assign rdAcc = chipSelect && readEn;
    assign tick = (state_ff == SHIFT_RUN) && (divCnt_ff == SCLK_HALF_CYC - 8'h01);
    assign done = tick && sclk_ff && (bitCnt_ff == 3'(SHIFT_BITS - 1));

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[STAT_BUSY_BIT] = (state_ff == SHIFT_RUN);
        statusWord[STAT_RXRDY_BIT] = rxReady_ff;
        statusWord[STAT_OVERRUN_BIT] = overrun_ff;
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rdPend = rdAcc;
        nxt_rdRom = rdAcc && (address <= OFS_ROM_LAST);
        nxt_rdWord = rdWord_ff;
        nxt_readValid = rdPend_ff;
        nxt_readData = readData_ff;
        nxt_control = control_ff;
        nxt_targetSel = targetSel_ff;
        nxt_marker = marker_ff;
        nxt_rxWord = rxWord_ff;
        nxt_txShift = txShift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_divCnt = divCnt_ff;
        nxt_rxReady = rxReady_ff;
        nxt_overrun = overrun_ff;
        nxt_sclk = sclk_ff;
        // register window read, captured beside the ROM read
        if (rdAcc)
        begin
            nxt_rdWord = 32'h0000_0000;
            if (address == OFS_RECEIVE_WORD)
            begin
                nxt_rdWord = {24'h00_0000, rxWord_ff};
                nxt_rxReady = 1'b0;
            end
            else if (address == OFS_LINK_STATUS)
            begin
                nxt_rdWord = statusWord;
            end
            else if (address == OFS_LINK_CONTROL)
            begin
                nxt_rdWord = control_ff;
            end
            else if (address == OFS_TARGET_SELECT)
            begin
                nxt_rdWord = targetSel_ff;
            end
            else if (address == OFS_LAST_WORD_MARKER)
            begin
                nxt_rdWord = marker_ff;
            end
        end
        if (rdPend_ff)
        begin
            nxt_readData = rdRom_ff ? romData : rdWord_ff;
        end
        // writes; ROM range, reserved and unmapped words fall through
        if (wrAcc)
        begin
            if (address == OFS_TRANSMIT_WORD)
            begin
                if (state_ff == SHIFT_IDLE)
                begin
                    nxt_state = SHIFT_RUN;
                    nxt_txShift = writeData[7:0];
                    nxt_bitCnt = 3'h0;
                    nxt_divCnt = 8'h00;
                    nxt_sclk = 1'b0;
                end
                else
                begin
                    nxt_overrun = 1'b1;
                end
            end
            else if (address == OFS_LINK_STATUS)
            begin
                nxt_overrun = 1'b0;
            end
            else if (address == OFS_LINK_CONTROL)
            begin
                nxt_control = writeData;
            end
            else if (address == OFS_TARGET_SELECT)
            begin
                nxt_targetSel = writeData;
            end
            else if (address == OFS_LAST_WORD_MARKER)
            begin
                nxt_marker = writeData;
            end
        end
        // serial shifter, mode 0, MSB first
        if (state_ff == SHIFT_RUN)
        begin
            nxt_divCnt = tick ? 8'h00 : divCnt_ff + 8'h01;
            if (tick)
            begin
                nxt_sclk = ~sclk_ff;
                if (sclk_ff)
                begin
                    // input read at the falling tick: the synchroniser lags a whole
                    // half period, so this is the bit that stood at the rising edge
                    nxt_rxWord = {rxWord_ff[6:0], dinVal_ff};
                    nxt_bitCnt = bitCnt_ff + 3'h1;
                    nxt_txShift = {txShift_ff[6:0], 1'b0};
                end
            end
        end
        // completion set wins over a same-cycle clearing read
        if (done)
        begin
            nxt_state = SHIFT_IDLE;
            nxt_rxReady = 1'b1;
        end
        nxt_dout = nxt_txShift[7];
        nxt_selN = ~(nxt_targetSel[SEL_TARGET0_BIT]
            && (nxt_state == SHIFT_RUN || nxt_control[CTRL_FORCE_SEL_BIT]));
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= SHIFT_IDLE;
            readData_ff <= 32'h0000_0000;
            readValid_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            rdRom_ff <= 1'b0;
            rdWord_ff <= 32'h0000_0000;
            control_ff <= RST_CONTROL;
            targetSel_ff <= RST_TARGET_SELECT;
            marker_ff <= RST_MARKER;
            rxWord_ff <= 8'h00;
            txShift_ff <= 8'h00;
            bitCnt_ff <= 3'h0;
            divCnt_ff <= 8'h00;
            rxReady_ff <= 1'b0;
            overrun_ff <= 1'b0;
            sclk_ff <= 1'b0;
            selN_ff <= 1'b1;
            dout_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            readData_ff <= nxt_readData;
            readValid_ff <= nxt_readValid;
            rdPend_ff <= nxt_rdPend;
            rdRom_ff <= nxt_rdRom;
            rdWord_ff <= nxt_rdWord;
            control_ff <= nxt_control;
            targetSel_ff <= nxt_targetSel;
            marker_ff <= nxt_marker;
            rxWord_ff <= nxt_rxWord;
            txShift_ff <= nxt_txShift;
            bitCnt_ff <= nxt_bitCnt;
            divCnt_ff <= nxt_divCnt;
            rxReady_ff <= nxt_rxReady;
            overrun_ff <= nxt_overrun;
            sclk_ff <= nxt_sclk;
            selN_ff <= nxt_selN;
            dout_ff <= nxt_dout;
        end
    end

    assign readData = readData_ff;
    assign readValid = readValid_ff;
    assign flashClk = sclk_ff;
    assign flashSelectN = selN_ff;
    assign flashDataOut = dout_ff;
endmodule : sbfp_top
`default_nettype wire

// file: sim/sbfp_top_props.sv
// sbfp_top_props: port-level assertions for the serial boot flash port
// assumes target select bit0 stays set and force select stays clear
`timescale 1ns/1ps
`default_nettype none
module sbfp_top_props
    import sbfp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // slave port
    input wire logic chipSelect,
    input wire logic [ADDR_W-1:0] address,
    input wire logic readEn,
    input wire logic writeEn,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic [DATA_W-1:0] readData,
    input wire logic readValid,
    // flash pins
    input wire logic flashClk,
    input wire logic flashSelectN,
    input wire logic flashDataOut,
    input wire logic flashDataIn
);
    logic [7:0] lowCnt_ff;
    logic [7:0] nxt_lowCnt;
    // frame length counted in clocks so no long repetition is unrolled
    always_comb nxt_lowCnt = flashSelectN ? 8'h00 : lowCnt_ff + 8'h01;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) lowCnt_ff <= 8'h00;
        else lowCnt_ff <= nxt_lowCnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_rdAt(logic [8:0] a);
        chipSelect && readEn && address == a;
    endsequence
    sequence s_start;
        chipSelect && writeEn && address == OFS_TRANSMIT_WORD && flashSelectN && !flashClk;
    endsequence
    a_read_latency: assert property (chipSelect && readEn |-> ##2 readValid)
        else $error("read answer not two cycles after request");
    a_valid_source: assert property (readValid |-> $past(readEn, 2) && $past(chipSelect, 2))
        else $error("read answer without a request");
    a_reserved_zero: assert property (s_rdAt(OFS_RESERVED_WORD) |-> ##2 readData == '0)
        else $error("reserved word read not zero");
    a_unmapped_zero: assert property (chipSelect && readEn && address > OFS_LAST_WORD_MARKER
        |-> ##2 readData == '0)
        else $error("unmapped word read not zero");
    a_idle_clock: assert property (flashSelectN |-> !flashClk)
        else $error("serial clock moves while deselected");
    a_start_frame: assert property (s_start |=> !flashSelectN && flashDataOut == $past(writeData[7]))
        else $error("transfer start wrong");
    a_half_period: assert property ($rose(flashClk) |-> flashClk[*4] ##1 !flashClk)
        else $error("serial clock high time wrong");
    a_frame_length: assert property ($rose(flashSelectN) |-> lowCnt_ff == 8'h40)
        else $error("frame length wrong");
endmodule : sbfp_top_props
bind sbfp_top sbfp_top_props u_props (.clk(clk), .resetn(resetn), .chipSelect(chipSelect),
    .address(address), .readEn(readEn), .writeEn(writeEn), .writeData(writeData),
    .readData(readData), .readValid(readValid), .flashClk(flashClk),
    .flashSelectN(flashSelectN), .flashDataOut(flashDataOut), .flashDataIn(flashDataIn));
`default_nettype wire

// file: sim/sbfp_flash_model.sv
// sbfp_flash_model: behavioural serial flash, one byte each way per frame
// assumes data set on falling serial clock and sampled on rising
`timescale 1ns/1ps
`default_nettype none
module sbfp_flash_model
(
    // flash pins
    input wire logic flashClk,
    input wire logic flashSelectN,
    input wire logic flashDataOut,
    output logic flashDataIn,
    // bench side
    input wire logic [7:0] replyByte,
    output logic [7:0] gotByte
);
    logic [7:0] shiftIn = 8'h00;
    int bitIdx = 0;
    initial flashDataIn = 1'b0;
    initial gotByte = 8'h00;
    always @(negedge flashSelectN)
    begin
        bitIdx = 7;
        flashDataIn = replyByte[7];
    end
    always @(posedge flashClk)
        if (!flashSelectN) shiftIn = {shiftIn[6:0], flashDataOut};
    always @(negedge flashClk)
    begin
        if (!flashSelectN && bitIdx > 0)
        begin
            bitIdx--;
            flashDataIn = replyByte[bitIdx];
        end
    end
    // released line shows the inverse so a stale bit cannot pass
    always @(posedge flashSelectN)
    begin
        gotByte = shiftIn;
        flashDataIn = ~flashDataIn;
    end
endmodule : sbfp_flash_model
`default_nettype wire

// file: sim/sbfp_top_tb_top.sv
// sbfp_top_tb_top: self-checking bench with register model and flash partner
// assumes reads answer two cycles after they are taken
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module sbfp_top_tb_top
    import sbfp_pkg::*;
;
    typedef logic [31:0] sbfp_img_t [ROM_WORDS];
    function automatic sbfp_img_t mkImg();
        sbfp_img_t m;
        for (int i = 0; i < ROM_WORDS; i++) m[i] = {8'(i), 8'h5A, ~8'(i), 8'hC3};
        return m;
    endfunction : mkImg
    localparam sbfp_img_t IMG = mkImg();
    logic clk = 1'b0, resetn = 1'b0, chipSelect = 1'b0, readEn = 1'b0, writeEn = 1'b0;
    logic [8:0] address = 9'h000;
    logic [31:0] writeData = 32'h0, readData, e, seed = 32'h3F93833A;
    logic readValid, flashClk, flashSelectN, flashDataOut, flashDataIn;
    logic [7:0] replyByte = 8'h00, gotByte;
    logic [31:0] expQ [$];
    int num_errors = 0, samples_checked = 0;
    sbfp_top #(.ROM_IMAGE(IMG)) DUT (.clk(clk), .resetn(resetn), .chipSelect(chipSelect),
        .address(address), .readEn(readEn), .writeEn(writeEn), .writeData(writeData),
        .readData(readData), .readValid(readValid), .flashClk(flashClk),
        .flashSelectN(flashSelectN), .flashDataOut(flashDataOut), .flashDataIn(flashDataIn));
    sbfp_flash_model u_flash (.flashClk(flashClk), .flashSelectN(flashSelectN),
        .flashDataOut(flashDataOut), .flashDataIn(flashDataIn), .replyByte(replyByte),
        .gotByte(gotByte));
    initial forever #4 clk = ~clk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic acc(logic w, logic [8:0] a, logic [31:0] d, logic [31:0] x);
        @(posedge clk);
        chipSelect <= 1'b1;
        readEn <= !w;
        writeEn <= w;
        address <= a;
        writeData <= d;
        if (!w) expQ.push_back(x);
    endtask : acc
    task automatic idle(int n);
        @(posedge clk);
        chipSelect <= 1'b0;
        readEn <= 1'b0;
        writeEn <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic waitFrame();
        int k;
        k = 0;
        while (flashSelectN !== 1'b1 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        if (k == 200) num_errors++;
    endtask : waitFrame
    // answers checked mid-cycle, away from the launching edge
    always @(negedge clk)
    begin
        if (readValid === 1'b1)
        begin
            e = (expQ.size() > 0) ? expQ.pop_front() : ~readData;
            `CHK("readData", e, readData)
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        acc(1'b0, 9'h000, 32'h0, IMG[0]);
        acc(1'b0, 9'h0FF, 32'h0, IMG[255]);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            acc(1'b0, {1'b0, seed[7:0]}, 32'h0, IMG[seed[7:0]]);
        end
        acc(1'b1, 9'h010, seed, 32'h0);
        acc(1'b0, 9'h010, 32'h0, IMG[16]);
        idle(3);
        $display("test rom done");
        acc(1'b0, OFS_TARGET_SELECT, 32'h0, RST_TARGET_SELECT);
        acc(1'b0, OFS_LINK_CONTROL, 32'h0, RST_CONTROL);
        acc(1'b0, OFS_LAST_WORD_MARKER, 32'h0, RST_MARKER);
        acc(1'b1, OFS_LAST_WORD_MARKER, seed, 32'h0);
        acc(1'b1, OFS_RESERVED_WORD, ~seed, 32'h0);
        acc(1'b0, OFS_LAST_WORD_MARKER, 32'h0, seed);
        acc(1'b0, OFS_RESERVED_WORD, 32'h0, 32'h0);
        acc(1'b0, OFS_TRANSMIT_WORD, 32'h0, 32'h0);
        acc(1'b0, 9'h107, 32'h0, 32'h0);
        acc(1'b0, 9'h1FF, 32'h0, 32'h0);
        acc(1'b0, OFS_LINK_STATUS, 32'h0, 32'h0);
        idle(3);
        $display("test regs done");
        for (int t = 0; t < 2; t++)
        begin
            seed = lfsr(seed);
            replyByte <= seed[15:8];
            acc(1'b1, OFS_TRANSMIT_WORD, {24'h0, seed[7:0]}, 32'h0);
            idle(2);
            acc(1'b0, OFS_LINK_STATUS, 32'h0, 32'h1);
            if (t == 1) acc(1'b1, OFS_TRANSMIT_WORD, 32'hFF, 32'h0);
            idle(1);
            waitFrame();
            `CHK("gotByte", seed[7:0], gotByte)
            acc(1'b0, OFS_LINK_STATUS, 32'h0, (t == 1) ? 32'h6 : 32'h2);
            acc(1'b1, OFS_LINK_STATUS, 32'h0, 32'h0);
            acc(1'b0, OFS_RECEIVE_WORD, 32'h0, {24'h0, seed[15:8]});
            idle(4);
            acc(1'b0, OFS_LINK_STATUS, 32'h0, 32'h0);
            idle(3);
        end
        $display("test link done");
        idle(3);
        `CHK("expQ", 32'h0, 32'(expQ.size()))
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule : sbfp_top_tb_top
`default_nettype wire
